// ===== shared/exec_pkg.sv
package exec_pkg;

    typedef enum logic [2:0] {
        op_none,
        rotate_left_carry_op,
        rotate_right_carry_op,
        literal_minus_acc_op,
        sleep_op
    } op_t;

    typedef struct packed {
        logic       valid;
        op_t        op;
        logic [6:0] file_addr;
        logic       dest;
        logic [7:0] literal;
    } instr_t;

    localparam int unsigned FILE_WORDS = 128;

    localparam logic [7:0] FILE_LAST    = 8'h7f;
    localparam logic [7:0] ADDR_ACC     = 8'h80;
    localparam logic [7:0] ADDR_STATUS  = 8'h81;
    localparam logic [7:0] ADDR_WDOG    = 8'h82;
    localparam logic [7:0] ADDR_CTRL    = 8'h83;

    localparam int unsigned ST_CARRY    = 0;
    localparam int unsigned ST_NIBBLE   = 1;
    localparam int unsigned ST_ZERO     = 2;
    localparam int unsigned ST_PD       = 3;
    localparam int unsigned ST_TO       = 4;
    localparam int unsigned ST_ASLEEP   = 5;
    localparam int unsigned CTRL_WAKE   = 0;

    localparam logic       DEST_ACC     = 1'b0;
    localparam logic [7:0] ACC_RESET    = 8'h00;
    localparam logic       PD_RESET     = 1'b1;
    localparam logic       TO_RESET     = 1'b1;
    localparam logic [7:0] WDOG_RESET   = 8'h00;
    localparam logic [7:0] PRESC_RESET  = 8'h00;
    localparam logic [7:0] PRESC_LAST   = 8'hff;

endpackage : exec_pkg

// ===== rtl/exec_unit.sv
// Summary of operation
// - left rotate moves the addressed file register up one bit, old carry into bit 0, old bit 7 into carry.
// - left rotate result goes to the accumulator when dest is 0, else back to the file register.
// - right rotate moves the addressed file register down one bit, old carry into bit 7, old bit 0 into carry.
// - right rotate result goes to the accumulator when dest is 0, else back to the file register.
// - sleep clears the watchdog counter and its prescaler.
// - sleep clears the power-down flag and sets the timeout status bit.
// - after sleep no instruction executes and the main oscillator enable drops until wake.
// - literal subtract puts literal minus accumulator into the accumulator and updates carry, nibble borrow and zero.
module exec_unit (
    input  wire logic            clk,
    input  wire logic            srst,
    input  wire exec_pkg::instr_t instr,
    input  wire logic [7:0]      bus_addr,
    input  wire logic [7:0]      bus_wdata,
    input  wire logic            bus_wr,
    input  wire logic            bus_rd,
    output logic      [7:0]      bus_rdata,
    output logic      [7:0]      acc,
    output logic                 asleep,
    output logic                 osc_run
);

    logic [7:0] file_mem [exec_pkg::FILE_WORDS];
    logic       carry;
    logic       nibble_borrow_flag;
    logic       zero;
    logic       power_down_flag;
    logic       timeout_status_bit;
    logic [7:0] watchdog_counter;
    logic [7:0] prescaler;

    logic       exec;
    logic [7:0] operand;
    logic [7:0] next_result;
    logic       next_carry;
    logic [8:0] diff;
    logic [4:0] diff_lo;
    logic       is_rot;
    logic       to_file;
    logic       wake;

    // a halted core ignores the instruction stream entirely
    assign exec    = instr.valid && !asleep;
    assign operand = file_mem[instr.file_addr];
    assign is_rot  = instr.op == exec_pkg::rotate_left_carry_op
                  || instr.op == exec_pkg::rotate_right_carry_op;
    assign to_file = exec && is_rot && instr.dest != exec_pkg::DEST_ACC;
    assign wake    = bus_wr && bus_addr == exec_pkg::ADDR_CTRL
                  && bus_wdata[exec_pkg::CTRL_WAKE];

    // two's complement: k + ~w + 1, carry out is the not-borrow
    assign diff    = {1'b0, instr.literal} + {1'b0, ~acc} + 9'h001;
    assign diff_lo = {1'b0, instr.literal[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

    always_comb begin
        next_result = operand;
        next_carry  = carry;
        case (instr.op)
            exec_pkg::rotate_left_carry_op: begin
                next_result = {operand[6:0], carry};
                next_carry  = operand[7];
            end
            exec_pkg::rotate_right_carry_op: begin
                next_result = {carry, operand[7:1]};
                next_carry  = operand[0];
            end
            exec_pkg::literal_minus_acc_op: begin
                next_result = diff[7:0];
                next_carry  = diff[8];
            end
            default: begin
                next_result = operand;
                next_carry  = carry;
            end
        endcase
    end

    // instruction write wins over a bus write to the same word
    always_ff @(posedge clk) begin
        if (bus_wr && bus_addr <= exec_pkg::FILE_LAST) begin
            file_mem[bus_addr[6:0]] <= bus_wdata;
        end
        if (to_file) begin
            file_mem[instr.file_addr] <= next_result;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            acc <= exec_pkg::ACC_RESET;
        end else if (exec && (instr.op == exec_pkg::literal_minus_acc_op
                || (is_rot && instr.dest == exec_pkg::DEST_ACC))) begin
            acc <= next_result;
        end else if (bus_wr && bus_addr == exec_pkg::ADDR_ACC) begin
            acc <= bus_wdata;
        end
    end

    // arithmetic flags; hardware update beats a software write
    always_ff @(posedge clk) begin
        if (srst) begin
            carry              <= 1'b0;
            nibble_borrow_flag <= 1'b0;
            zero               <= 1'b0;
        end else if (exec && instr.op == exec_pkg::literal_minus_acc_op) begin
            carry              <= next_carry;
            nibble_borrow_flag <= diff_lo[4];
            zero               <= diff[7:0] == 8'h00;
        end else if (exec && is_rot) begin
            carry <= next_carry;
        end else if (bus_wr && bus_addr == exec_pkg::ADDR_STATUS) begin
            carry              <= bus_wdata[exec_pkg::ST_CARRY];
            nibble_borrow_flag <= bus_wdata[exec_pkg::ST_NIBBLE];
            zero               <= bus_wdata[exec_pkg::ST_ZERO];
        end
    end

    // power-down and timeout are read-only to software
    always_ff @(posedge clk) begin
        if (srst) begin
            power_down_flag    <= exec_pkg::PD_RESET;
            timeout_status_bit <= exec_pkg::TO_RESET;
        end else if (exec && instr.op == exec_pkg::sleep_op) begin
            power_down_flag    <= 1'b0;
            timeout_status_bit <= 1'b1;
        end
    end

    // watchdog keeps counting in sleep, as on its own oscillator
    always_ff @(posedge clk) begin
        if (srst || (exec && instr.op == exec_pkg::sleep_op)) begin
            watchdog_counter <= exec_pkg::WDOG_RESET;
            prescaler        <= exec_pkg::PRESC_RESET;
        end else begin
            prescaler <= prescaler + 8'h01;
            if (prescaler == exec_pkg::PRESC_LAST) begin
                watchdog_counter <= watchdog_counter + 8'h01;
            end
        end
    end

    // wake only by software; a sleep in the same cycle wins over the wake
    always_ff @(posedge clk) begin
        if (srst) begin
            asleep  <= 1'b0;
            osc_run <= 1'b1;
        end else if (exec && instr.op == exec_pkg::sleep_op) begin
            asleep  <= 1'b1;
            osc_run <= 1'b0;
        end else if (wake) begin
            asleep  <= 1'b0;
            osc_run <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bus_rdata <= 8'h00;
        end else if (bus_rd) begin
            if (bus_addr <= exec_pkg::FILE_LAST) begin
                bus_rdata <= file_mem[bus_addr[6:0]];
            end else if (bus_addr == exec_pkg::ADDR_ACC) begin
                bus_rdata <= acc;
            end else if (bus_addr == exec_pkg::ADDR_STATUS) begin
                bus_rdata <= {2'b00, asleep, timeout_status_bit, power_down_flag,
                              zero, nibble_borrow_flag, carry};
            end else if (bus_addr == exec_pkg::ADDR_WDOG) begin
                bus_rdata <= watchdog_counter;
            end else begin
                bus_rdata <= 8'h00;
            end
        end else begin
            bus_rdata <= 8'h00;
        end
    end

    sequence rotl_acc_s;
        exec && instr.op == exec_pkg::rotate_left_carry_op && instr.dest == 1'b0;
    endsequence

    sequence rotr_acc_s;
        exec && instr.op == exec_pkg::rotate_right_carry_op && instr.dest == 1'b0;
    endsequence

    sequence sleep_s;
        exec && instr.op == exec_pkg::sleep_op;
    endsequence

    sequence rotl_file_s;
        exec && instr.op == exec_pkg::rotate_left_carry_op && instr.dest == 1'b1;
    endsequence

    sequence sub_s;
        exec && instr.op == exec_pkg::literal_minus_acc_op;
    endsequence

    // a bus write to the same word in that cycle would legally change it,
    // so the keep checks only look where the bus leaves the word alone
    sequence word_quiet_s;
        !(bus_wr && bus_addr == {1'b0, instr.file_addr});
    endsequence

    a_rotl_acc_value: assert property (@(posedge clk) disable iff (srst)
        rotl_acc_s |=> acc == {$past(operand[6:0]), $past(carry)} && carry == $past(operand[7]))
        else $error("left rotate result wrong");

    a_rotr_acc_value: assert property (@(posedge clk) disable iff (srst)
        rotr_acc_s |=> acc == {$past(carry), $past(operand[7:1])} && carry == $past(operand[0]))
        else $error("right rotate result wrong");

    a_rot_file_dest: assert property (@(posedge clk) disable iff (srst)
        exec && is_rot && instr.dest && !(bus_wr && bus_addr == exec_pkg::ADDR_ACC)
        |=> acc == $past(acc))
        else $error("rotate to file disturbed accumulator");

    a_rot_file_word: assert property (@(posedge clk) disable iff (srst)
        exec && instr.op == exec_pkg::rotate_right_carry_op && instr.dest
        |=> file_mem[$past(instr.file_addr)] == {$past(carry), $past(operand[7:1])})
        else $error("right rotate file write wrong");

    a_sleep_wdog_clear: assert property (@(posedge clk) disable iff (srst)
        sleep_s |=> watchdog_counter == 8'h00 && prescaler == 8'h00 ##1 prescaler == 8'h01)
        else $error("watchdog not cleared by sleep");

    a_sleep_status: assert property (@(posedge clk) disable iff (srst)
        sleep_s |=> !power_down_flag && timeout_status_bit)
        else $error("sleep status bits wrong");

    a_sleep_halt: assert property (@(posedge clk) disable iff (srst)
        sleep_s ##1 (!wake && !(bus_wr && bus_addr == exec_pkg::ADDR_ACC))[*3]
        |=> asleep && !osc_run && acc == $past(acc, 3))
        else $error("core kept running in sleep");

    a_sub_result: assert property (@(posedge clk) disable iff (srst)
        exec && instr.op == exec_pkg::literal_minus_acc_op
        |=> acc == 8'($past(instr.literal) - $past(acc))
            && carry == ($past(acc) <= $past(instr.literal))
            && zero == (acc == 8'h00))
        else $error("literal subtract wrong");

    a_rot_flags_keep: assert property (@(posedge clk) disable iff (srst)
        exec && is_rot |=> $stable(zero) && $stable(nibble_borrow_flag))
        else $error("rotate touched zero or nibble flag");

    a_rotl_file_word: assert property (@(posedge clk) disable iff (srst)
        rotl_file_s
        |=> file_mem[$past(instr.file_addr)] == {$past(operand[6:0]), $past(carry)})
        else $error("left rotate file write wrong");

    a_rotl_file_keep: assert property (@(posedge clk) disable iff (srst)
        rotl_acc_s ##0 word_quiet_s
        |=> file_mem[$past(instr.file_addr)] == $past(operand))
        else $error("left rotate to accumulator changed file word");

    a_rotr_file_keep: assert property (@(posedge clk) disable iff (srst)
        rotr_acc_s ##0 word_quiet_s
        |=> file_mem[$past(instr.file_addr)] == $past(operand))
        else $error("right rotate to accumulator changed file word");

    a_sub_file_keep: assert property (@(posedge clk) disable iff (srst)
        sub_s ##0 word_quiet_s
        |=> file_mem[$past(instr.file_addr)] == $past(operand))
        else $error("subtract changed file word");

    a_sub_nibble_flag: assert property (@(posedge clk) disable iff (srst)
        sub_s |=> nibble_borrow_flag == ($past(acc[3:0]) <= $past(instr.literal[3:0])))
        else $error("subtract nibble flag wrong");

    a_sleep_osc_off: assert property (@(posedge clk) disable iff (srst)
        asleep |-> !osc_run)
        else $error("oscillator running while asleep");

    a_asleep_flags_hold: assert property (@(posedge clk) disable iff (srst)
        asleep && instr.valid && !(bus_wr && bus_addr == exec_pkg::ADDR_STATUS)
        |=> $stable(carry) && $stable(zero) && $stable(nibble_borrow_flag))
        else $error("instruction changed flags while asleep");

    a_asleep_acc_hold: assert property (@(posedge clk) disable iff (srst)
        asleep && !(bus_wr && bus_addr == exec_pkg::ADDR_ACC)
        |=> acc == $past(acc))
        else $error("instruction changed accumulator while asleep");

    a_sleep_stays: assert property (@(posedge clk) disable iff (srst)
        asleep && !wake |=> asleep)
        else $error("left sleep without wake");

    a_wdog_stays_zero: assert property (@(posedge clk) disable iff (srst)
        sleep_s |-> ##256 watchdog_counter == 8'h00)
        else $error("watchdog moved too early after sleep");

    a_status_read: assert property (@(posedge clk) disable iff (srst)
        bus_rd && bus_addr == exec_pkg::ADDR_STATUS
        |=> bus_rdata[exec_pkg::ST_PD] == $past(power_down_flag)
            && bus_rdata[exec_pkg::ST_TO] == $past(timeout_status_bit))
        else $error("status read lost power-down or timeout bit");

    a_wdog_read: assert property (@(posedge clk) disable iff (srst)
        bus_rd && bus_addr == exec_pkg::ADDR_WDOG |=> bus_rdata == $past(watchdog_counter))
        else $error("watchdog read wrong");

    a_rot_sleep_bits: assert property (@(posedge clk) disable iff (srst)
        exec && is_rot |=> $stable(power_down_flag) && $stable(timeout_status_bit))
        else $error("rotate touched power-down or timeout bit");

    a_wake_resume: assert property (@(posedge clk) disable iff (srst)
        asleep && wake |=> !asleep && osc_run)
        else $error("wake did not restart the core");

endmodule : exec_unit

// ===== tb/rotate_subtract_sleep_ops_tb.sv
module rotate_subtract_sleep_ops_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic             clk;
    logic             srst;
    exec_pkg::instr_t instr;
    logic [7:0]       bus_addr;
    logic [7:0]       bus_wdata;
    logic             bus_wr;
    logic             bus_rd;
    logic [7:0]       bus_rdata;
    logic [7:0]       acc;
    logic             asleep;
    logic             osc_run;
    int               fail_count;
    int               num_checks;
    logic [7:0]       ks [4] = '{8'h10, 8'h05, 8'h02, 8'hff};
    logic [7:0]       ws [4] = '{8'h05, 8'h05, 8'h05, 8'h0f};

    exec_unit uut (
        .clk       (clk),
        .srst      (srst),
        .instr     (instr),
        .bus_addr  (bus_addr),
        .bus_wdata (bus_wdata),
        .bus_wr    (bus_wr),
        .bus_rd    (bus_rd),
        .bus_rdata (bus_rdata),
        .acc       (acc),
        .asleep    (asleep),
        .osc_run   (osc_run)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge clk);
        bus_wr    <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe, so sample just past that edge
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clk);
        bus_rd   <= 1'b0;
        #1;
        chk(bus_rdata, exp);
    endtask : rd_chk

    task automatic exec(input exec_pkg::op_t op, input logic [6:0] fa, input logic dst,
                        input logic [7:0] k);
        @(posedge clk);
        instr <= {1'b1, op, fa, dst, k};
        @(posedge clk);
        instr.valid <= 1'b0;
        #1;
    endtask : exec

    task automatic results;
        if (fail_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        results();
    end

    initial begin
        logic [7:0] res;
        logic       c;
        logic       dc;
        logic       z;
        fail_count = 0;
        num_checks = 0;
        srst       = 1'b1;
        instr      = '0;
        bus_addr   = 8'h00;
        bus_wdata  = 8'h00;
        bus_wr     = 1'b0;
        bus_rd     = 1'b0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        rd_chk(exec_pkg::ADDR_STATUS, 8'h18);
        chk(acc, exec_pkg::ACC_RESET);
        // zero and nibble flags preset so a rotate that touches them shows up
        wr(8'h05, 8'he6);
        wr(exec_pkg::ADDR_STATUS, 8'h06);
        exec(exec_pkg::rotate_left_carry_op, 7'h05, 1'b0, 8'h00);
        chk(acc, 8'hcc);
        rd_chk(exec_pkg::ADDR_STATUS, 8'h1f);
        rd_chk(8'h05, 8'he6);
        exec(exec_pkg::rotate_left_carry_op, 7'h05, 1'b1, 8'h00);
        rd_chk(8'h05, 8'hcd);
        chk(acc, 8'hcc);
        exec(exec_pkg::rotate_right_carry_op, 7'h05, 1'b0, 8'h00);
        chk(acc, 8'he6);
        rd_chk(exec_pkg::ADDR_STATUS, 8'h1f);
        wr(exec_pkg::ADDR_STATUS, 8'h00);
        wr(8'h7f, 8'h01);
        exec(exec_pkg::rotate_right_carry_op, 7'h7f, 1'b1, 8'h00);
        rd_chk(8'h7f, 8'h00);
        rd_chk(exec_pkg::ADDR_STATUS, 8'h19);
        // dest set on purpose: the subtract result must still land in the accumulator
        for (int i = 0; i < 4; i++) begin
            wr(exec_pkg::ADDR_ACC, ws[i]);
            exec(exec_pkg::literal_minus_acc_op, 7'h05, 1'b1, ks[i]);
            res = ks[i] - ws[i];
            c   = ws[i] <= ks[i];
            dc  = ws[i][3:0] <= ks[i][3:0];
            z   = res == 8'h00;
            chk(acc, res);
            rd_chk(exec_pkg::ADDR_STATUS, {3'b000, 2'b11, z, dc, c});
        end
        rd_chk(8'h05, 8'hcd);
        // let the watchdog move off zero so its clearing is visible
        repeat (300) @(posedge clk);
        exec(exec_pkg::sleep_op, 7'h00, 1'b0, 8'h00);
        chk({6'h00, asleep, osc_run}, 8'h02);
        rd_chk(exec_pkg::ADDR_STATUS, 8'h33);
        rd_chk(exec_pkg::ADDR_WDOG, 8'h00);
        exec(exec_pkg::rotate_left_carry_op, 7'h05, 1'b0, 8'h00);
        chk(acc, 8'hf0);
        rd_chk(exec_pkg::ADDR_STATUS, 8'h33);
        // a stale prescaler would wrap inside this gap and bump the counter
        repeat (190) @(posedge clk);
        rd_chk(exec_pkg::ADDR_WDOG, 8'h00);
        wr(exec_pkg::ADDR_CTRL, 8'h01);
        #1;
        chk({6'h00, asleep, osc_run}, 8'h01);
        exec(exec_pkg::rotate_left_carry_op, 7'h05, 1'b0, 8'h00);
        chk(acc, 8'h9b);
        results();
    end
endmodule : rotate_subtract_sleep_ops_tb
